// ===== pfm_pad_cell.sv
`timescale 1ns/1ns
package pfm_pkg;
  // ==========================================================
  // sizes and codes
  localparam int NPAD = 4;
  localparam int NMODE = 16;
  localparam int NIN = 4;
  localparam logic [3:0] MODE_PRIMARY = 4'h0;
  localparam logic [3:0] MODE_HIZ = 4'hF;

  // pad state codes
  localparam logic [2:0] ST_DRV0 = 3'h0;
  localparam logic [2:0] ST_DRV1 = 3'h1;
  localparam logic [2:0] ST_OFF = 3'h2;
  localparam logic [2:0] ST_PULL_LO = 3'h3;
  localparam logic [2:0] ST_PULL_HI = 3'h4;
  localparam logic [2:0] ST_CLK = 3'h5;

  // deselected input value codes
  localparam logic [1:0] DESEL_ZERO = 2'h0;
  localparam logic [1:0] DESEL_ONE = 2'h1;
  localparam logic [1:0] DESEL_PIN = 2'h2;

  typedef enum logic {PH_HOLD, PH_LIVE} pfm_phase_t;

  // ==========================================================
  // per-pad attributes
  localparam logic [2:0] POR_STATE [NPAD] =
    '{ST_PULL_LO, ST_OFF, ST_DRV0, ST_PULL_HI};
  localparam logic [2:0] REL_STATE [NPAD] =
    '{ST_PULL_LO, ST_CLK, ST_DRV1, ST_PULL_HI};
  localparam logic [3:0] REL_MODE [NPAD] = '{4'h0, 4'h3, 4'h1, 4'h7};
  localparam logic [15:0] DEF_MODES [NPAD] =
    '{16'h8005, 16'h800B, 16'h8007, 16'h8083};
  localparam logic [NPAD-1:0] HAS_PULL_HI = 4'hB;
  localparam logic [NPAD-1:0] HAS_PULL_LO = 4'hD;
  localparam logic [NPAD-1:0] PULL_EN_RST = 4'h9;
  localparam logic [NPAD-1:0] PULL_UP_RST = 4'h8;

  // ==========================================================
  // peripheral input sources
  localparam logic [1:0] IN_A_PAD [NIN] = '{2'h0, 2'h1, 2'h2, 2'h3};
  localparam logic [3:0] IN_A_MODE [NIN] = '{4'h0, 4'h3, 4'h0, 4'h0};
  localparam logic [1:0] IN_B_PAD [NIN] = '{2'h2, 2'h3, 2'h1, 2'h0};
  localparam logic [3:0] IN_B_MODE [NIN] = '{4'h2, 4'h1, 4'h1, 4'h2};
  localparam logic [1:0] IN_DESEL [NIN] =
    '{DESEL_ZERO, DESEL_ONE, DESEL_PIN, DESEL_PIN};
  localparam logic [1:0] IN_HOME_PAD [NIN] = '{2'h0, 2'h1, 2'h2, 2'h3};
endpackage

module pfm_pad_cell (
  input wire logic hold_i,          // power-on state phase
  input wire logic ovr_i,           // release state still applied
  input wire logic [2:0] por_st_i,  // power-on state code
  input wire logic [2:0] rel_st_i,  // release state code
  input wire logic [3:0] mode_i,    // selected mode
  input wire logic [15:0] def_i,    // defined modes mask
  input wire logic pull_en_i,       // pull enable
  input wire logic pull_up_i,       // pull direction, 1 = up
  input wire logic has_hi_i,        // pullup exists
  input wire logic has_lo_i,        // pulldown exists
  input wire logic [15:0] fout_i,   // function outputs per mode
  input wire logic [15:0] foe_i,    // function enables per mode
  input wire logic clk_tgl_i,       // toggling clock level
  output logic out_o,               // pad output level
  output logic oe_o,                // pad driver enable
  output logic pull_hi_o,           // pullup on
  output logic pull_lo_o            // pulldown on
);
  logic [2:0] st;

  always_comb begin
    st = hold_i ? por_st_i : rel_st_i;
    out_o = 1'b0;
    oe_o = 1'b0;
    pull_hi_o = 1'b0;
    pull_lo_o = 1'b0;
    if (hold_i || ovr_i) begin
      unique case (st)
        pfm_pkg::ST_DRV0: oe_o = 1'b1;
        pfm_pkg::ST_DRV1: begin
          oe_o = 1'b1;
          out_o = 1'b1;
        end
        pfm_pkg::ST_CLK: begin
          oe_o = 1'b1;
          out_o = clk_tgl_i;
        end
        pfm_pkg::ST_PULL_LO: pull_lo_o = has_lo_i;
        pfm_pkg::ST_PULL_HI: pull_hi_o = has_hi_i;
        pfm_pkg::ST_OFF: oe_o = 1'b0;
        default: oe_o = 1'b0;
      endcase
    end else begin
      // hiz setting and undefined modes leave the driver off
      if (mode_i != pfm_pkg::MODE_HIZ && def_i[mode_i]) begin
        oe_o = foe_i[mode_i];
        out_o = fout_i[mode_i] & foe_i[mode_i];
      end
      if (pull_en_i) begin
        if (has_hi_i && has_lo_i) begin
          pull_hi_o = pull_up_i;
          pull_lo_o = ~pull_up_i;
        end else begin
          pull_hi_o = has_hi_i;
          pull_lo_o = has_lo_i;
        end
      end
    end
  end
endmodule

// ===== pfm_pad_mux.sv
// Function
// - mode 0 routes the pad's primary function
// - default mode is the mode at release
// - warm reset release loads release mode
// - power-on reset applies per-pad reset state
// - warm release applies per-pad release state
// - driver off puts pad in high impedance
// - software enables pulls and picks direction on pads that have both pulls
// - unselected peripheral input gets deselected value
// - high impedance pad is never a selected input source, but still feeds a pin deselected value
`timescale 1ns/1ns
module pfm_pad_mux (
  input wire logic MCLK_I,                        // 20 MHz clock
  input wire logic RESET_I,                       // power-on reset, sync
  input wire logic SYSTEM_WARM_RESET_OUTPUT_I,    // warm reset out, high
  input wire logic CFG_WE_I,                      // config write strobe
  input wire logic [1:0] CFG_PAD_I,               // pad written
  input wire logic [3:0] CFG_MODE_I,              // mode to write
  input wire logic CFG_PULL_EN_I,                 // pull enable to write
  input wire logic CFG_PULL_UP_I,                 // pull direction
  input wire logic [63:0] FUNC_OUT_I,             // pad*16+mode outputs
  input wire logic [63:0] FUNC_OE_I,              // pad*16+mode enables
  input wire logic [3:0] PAD_IN_I,                // pad levels
  output logic [15:0] CFG_MODE_O,                 // mode fields, pad*4
  output logic [3:0] CFG_PULL_EN_O,               // pull enables
  output logic [3:0] CFG_PULL_UP_O,               // pull directions
  output logic [3:0] PAD_OUT_O,                   // pad output level
  output logic [3:0] PAD_OE_O,                    // pad driver enable
  output logic [3:0] PULLUP_ACTIVE_O,             // pullup on
  output logic [3:0] PULLDOWN_ACTIVE_O,           // pulldown on
  output logic [3:0] PERIPH_IN_O                  // peripheral inputs
);
  localparam int NP = pfm_pkg::NPAD;
  localparam int NM = pfm_pkg::NMODE;

  // ==========================================================
  // configuration and phase
  pfm_pkg::pfm_phase_t ph_r, ph_nxt;
  logic [NP-1:0][3:0] mode_r, mode_nxt;
  logic [NP-1:0] pull_en_r, pull_en_nxt;
  logic [NP-1:0] pull_up_r, pull_up_nxt;
  logic [NP-1:0] ovr_r, ovr_nxt;
  logic clk_tgl_r, clk_tgl_nxt;
  logic warm;

  assign warm = SYSTEM_WARM_RESET_OUTPUT_I;

  always_comb begin
    ph_nxt = ph_r;
    mode_nxt = mode_r;
    pull_en_nxt = pull_en_r;
    pull_up_nxt = pull_up_r;
    ovr_nxt = ovr_r;
    clk_tgl_nxt = ~clk_tgl_r;
    unique case (ph_r)
      pfm_pkg::PH_HOLD: begin
        if (!warm) begin
          ph_nxt = pfm_pkg::PH_LIVE;
          for (int i = 0; i < NP; i++) begin
            mode_nxt[i] = pfm_pkg::REL_MODE[i];
          end
          pull_en_nxt = pfm_pkg::PULL_EN_RST;
          pull_up_nxt = pfm_pkg::PULL_UP_RST;
          ovr_nxt = '1;
        end
      end
      pfm_pkg::PH_LIVE: begin
        if (warm) begin
          ph_nxt = pfm_pkg::PH_HOLD;
        end else if (CFG_WE_I) begin
          mode_nxt[CFG_PAD_I] = CFG_MODE_I;
          pull_en_nxt[CFG_PAD_I] = CFG_PULL_EN_I;
          pull_up_nxt[CFG_PAD_I] = CFG_PULL_UP_I;
          ovr_nxt[CFG_PAD_I] = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ph_r <= pfm_pkg::PH_HOLD;
      for (int i = 0; i < NP; i++) begin
        mode_r[i] <= pfm_pkg::REL_MODE[i];
      end
      pull_en_r <= pfm_pkg::PULL_EN_RST;
      pull_up_r <= pfm_pkg::PULL_UP_RST;
      ovr_r <= '1;
      clk_tgl_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      mode_r <= mode_nxt;
      pull_en_r <= pull_en_nxt;
      pull_up_r <= pull_up_nxt;
      ovr_r <= ovr_nxt;
      clk_tgl_r <= clk_tgl_nxt;
    end
  end

  assign CFG_MODE_O = mode_r;
  assign CFG_PULL_EN_O = pull_en_r;
  assign CFG_PULL_UP_O = pull_up_r;

  // ==========================================================
  // pad input synchroniser, three stages
  logic [NP-1:0] s1_r, s2_r, s3_r, pad_val_r;
  logic [NP-1:0] pad_val_nxt;

  always_comb begin
    pad_val_nxt = pad_val_r;
    for (int i = 0; i < NP; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        pad_val_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pad_val_r <= '0;
    end else begin
      s1_r <= PAD_IN_I;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pad_val_r <= pad_val_nxt;
    end
  end

  // ==========================================================
  // pad drive
  logic [NP-1:0] c_out, c_oe, c_hi, c_lo;
  logic hold;

  // reset itself selects the power-on state so pads settle at once
  assign hold = RESET_I || (ph_r == pfm_pkg::PH_HOLD);

  for (genvar g = 0; g < NP; g++) begin : g_pad
    pfm_pad_cell pfm_pad_cell_i (
      .hold_i(hold),
      .ovr_i(ovr_r[g]),
      .por_st_i(pfm_pkg::POR_STATE[g]),
      .rel_st_i(pfm_pkg::REL_STATE[g]),
      .mode_i(mode_r[g]),
      .def_i(pfm_pkg::DEF_MODES[g]),
      .pull_en_i(pull_en_r[g]),
      .pull_up_i(pull_up_r[g]),
      .has_hi_i(pfm_pkg::HAS_PULL_HI[g]),
      .has_lo_i(pfm_pkg::HAS_PULL_LO[g]),
      .fout_i(FUNC_OUT_I[g*NM +: NM]),
      .foe_i(FUNC_OE_I[g*NM +: NM]),
      .clk_tgl_i(clk_tgl_r),
      .out_o(c_out[g]),
      .oe_o(c_oe[g]),
      .pull_hi_o(c_hi[g]),
      .pull_lo_o(c_lo[g])
    );
  end

  // ==========================================================
  // peripheral input selection
  logic [pfm_pkg::NIN-1:0] periph_nxt;

  always_comb begin
    periph_nxt = '0;
    for (int k = 0; k < pfm_pkg::NIN; k++) begin
      // a pad in the hiz setting never matches a source mode
      if (mode_r[pfm_pkg::IN_A_PAD[k]] == pfm_pkg::IN_A_MODE[k]) begin
        periph_nxt[k] = pad_val_r[pfm_pkg::IN_A_PAD[k]];
      end else if (mode_r[pfm_pkg::IN_B_PAD[k]] ==
          pfm_pkg::IN_B_MODE[k]) begin
        periph_nxt[k] = pad_val_r[pfm_pkg::IN_B_PAD[k]];
      end else begin
        unique case (pfm_pkg::IN_DESEL[k])
          pfm_pkg::DESEL_ZERO: periph_nxt[k] = 1'b0;
          pfm_pkg::DESEL_ONE: periph_nxt[k] = 1'b1;
          pfm_pkg::DESEL_PIN:
            periph_nxt[k] = pad_val_r[pfm_pkg::IN_HOME_PAD[k]];
          default: periph_nxt[k] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    PAD_OUT_O <= c_out;
    PAD_OE_O <= c_oe;
    PULLUP_ACTIVE_O <= c_hi;
    PULLDOWN_ACTIVE_O <= c_lo;
    if (RESET_I) begin
      PERIPH_IN_O <= '0;
    end else begin
      PERIPH_IN_O <= periph_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_warm_fall;
    ph_r == pfm_pkg::PH_HOLD && !warm;
  endsequence

  sequence s_quiet;
    !warm && !CFG_WE_I;
  endsequence

  chk_mode_load: assert property (
    s_warm_fall |=> mode_r[1] == 4'h3 && mode_r[3] == 4'h7 && ovr_r == 4'hF)
    else $error("release mode not loaded");

  chk_default_mode: assert property (
    s_warm_fall |=> mode_r[2] == 4'h1 && mode_r[0] == 4'h0)
    else $error("default mode wrong after release");

  chk_rel_state: assert property (
    s_warm_fall ##1 s_quiet |=> PAD_OE_O[1] && PAD_OE_O[2] && PAD_OUT_O[2]
      && PULLDOWN_ACTIVE_O[0] && PULLUP_ACTIVE_O[3]
      ##1 PAD_OUT_O[1] != $past(PAD_OUT_O[1]))
    else $error("release state not applied");

  chk_por_state: assert property (
    ph_r == pfm_pkg::PH_HOLD |=> PAD_OE_O == 4'h4 && !PAD_OUT_O[2]
      && PULLDOWN_ACTIVE_O == 4'h1 && PULLUP_ACTIVE_O == 4'h8)
    else $error("power-on pad state wrong");

  chk_cfg_write: assert property (
    CFG_WE_I && ph_r == pfm_pkg::PH_LIVE && !warm |=>
      mode_r[$past(CFG_PAD_I)] == $past(CFG_MODE_I)
      && !ovr_r[$past(CFG_PAD_I)])
    else $error("config write lost");

  chk_pull_off: assert property (
    ph_r == pfm_pkg::PH_LIVE && ovr_r == 4'h0 && pull_en_r == 4'h0 |=>
      PULLUP_ACTIVE_O == 4'h0 && PULLDOWN_ACTIVE_O == 4'h0)
    else $error("pull active while disabled");

  chk_pull_excl: assert property (
    (PULLUP_ACTIVE_O & PULLDOWN_ACTIVE_O) == 4'h0)
    else $error("pullup and pulldown both on");

  chk_hiz_off: assert property (
    ph_r == pfm_pkg::PH_LIVE && !ovr_r[0]
      && mode_r[0] == pfm_pkg::MODE_HIZ |=> !PAD_OE_O[0])
    else $error("hiz pad driven");

  chk_primary_route: assert property (
    ph_r == pfm_pkg::PH_LIVE && !ovr_r[0] && mode_r[0] == 4'h0 |=>
      PAD_OE_O[0] == $past(FUNC_OE_I[0])
      && PAD_OUT_O[0] == ($past(FUNC_OUT_I[0]) & $past(FUNC_OE_I[0])))
    else $error("primary function not routed");

  chk_deselect_val: assert property (
    mode_r[0] != 4'h0 && mode_r[2] != 4'h2 && mode_r[1] != 4'h3
      && mode_r[3] != 4'h1 |=> !PERIPH_IN_O[0] && PERIPH_IN_O[1])
    else $error("deselected input value wrong");
endmodule

// ===== pfm_pad_far.sv
`timescale 1ns/1ns
// ==========================================================
// far side: level seen on each ball
module pfm_pad_far (
  input wire logic [3:0] oe_i,   // pad driver enable
  input wire logic [3:0] out_i,  // pad output level
  input wire logic [3:0] pull_hi_i,  // pullup on
  input wire logic [3:0] pull_lo_i,  // pulldown on
  input wire logic [3:0] ext_i,  // outside level on floating pad
  output logic [3:0] pad_o       // resolved ball level
);
  // released ball follows its pull, else the outside level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_o[i] = oe_i[i] ? out_i[i] :
        pull_hi_i[i] | (~pull_lo_i[i] & ext_i[i]);
    end
  end
endmodule

// ===== pfm_pad_mux_tb.sv
`timescale 1ns/1ns
module pfm_pad_mux_tb;
  typedef struct {int kind; logic [23:0] exp; logic [23:0] msk; int at;}
    pfm_note_t;
  logic mclk = 1'b0, rst = 1'b1, warm = 1'b1, we = 1'b0;
  logic wpe = 1'b0, wpu = 1'b0, prev1 = 1'b0;
  logic [1:0] wpad = 2'h0;
  logic [3:0] wmode = 4'h0, ext = 4'h0, pen, pup, ovr, pad_lvl, pin;
  logic [63:0] fo = 64'h0, fe = 64'h0;
  logic [15:0] mode_o;
  logic [3:0] pen_o, pup_o, oe_o, out_o, pull_hi_o, pull_lo_o, in_o;
  logic [3:0] md [4];
  logic [23:0] msk;
  logic [31:0] seed = 32'h17;
  int cyc = 0, fails = 0, tests_run = 0;
  pfm_note_t nq [$];
  pfm_note_t n;

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge mclk) if (cyc == 3000) begin
    fails++;
    finish_test();
  end

  pfm_pad_mux pfm_pad_mux_i (.MCLK_I(mclk), .RESET_I(rst),
    .SYSTEM_WARM_RESET_OUTPUT_I(warm), .CFG_WE_I(we), .CFG_PAD_I(wpad),
    .CFG_MODE_I(wmode), .CFG_PULL_EN_I(wpe), .CFG_PULL_UP_I(wpu),
    .FUNC_OUT_I(fo), .FUNC_OE_I(fe), .PAD_IN_I(pin), .CFG_MODE_O(mode_o),
    .CFG_PULL_EN_O(pen_o), .CFG_PULL_UP_O(pup_o), .PAD_OUT_O(out_o),
    .PAD_OE_O(oe_o), .PULLUP_ACTIVE_O(pull_hi_o),
    .PULLDOWN_ACTIVE_O(pull_lo_o),
    .PERIPH_IN_O(in_o));
  pfm_pad_far pfm_pad_far_i (.oe_i(oe_o), .out_i(out_o),
    .pull_hi_i(pull_hi_o), .pull_lo_i(pull_lo_o), .ext_i(ext),
    .pad_o(pin));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [3:0] st_bits(input logic [2:0] s);
    return {s == pfm_pkg::ST_DRV0 || s == pfm_pkg::ST_DRV1 ||
      s == pfm_pkg::ST_CLK, s == pfm_pkg::ST_DRV1,
      s == pfm_pkg::ST_PULL_HI, s == pfm_pkg::ST_PULL_LO};
  endfunction

  // {oe, out, pullup, pulldown, pad1 toggled}
  function automatic logic [16:0] pad_exp(input bit por);
    logic [3:0] oe, ou, hi, lo, b, m;
    for (int p = 0; p < 4; p++) begin
      m = md[p];
      if (por || ovr[p]) begin
        b = st_bits(por ? pfm_pkg::POR_STATE[p] : pfm_pkg::REL_STATE[p]);
      end else begin
        b[3] = m != pfm_pkg::MODE_HIZ && pfm_pkg::DEF_MODES[p][m] &&
          fe[p*16+m];
        b[2] = b[3] & fo[p*16+m];
        b[1] = pen[p] & pfm_pkg::HAS_PULL_HI[p] &
          (pup[p] | ~pfm_pkg::HAS_PULL_LO[p]);
        b[0] = pen[p] & pfm_pkg::HAS_PULL_LO[p] &
          (~pup[p] | ~pfm_pkg::HAS_PULL_HI[p]);
      end
      {oe[p], ou[p], hi[p], lo[p]} = b;
      pad_lvl[p] = oe[p] ? ou[p] : hi[p] | (~lo[p] & ext[p]);
    end
    msk = (!por && ovr[1]) ? 24'hFFFBFF : 24'hFFFFFE;
    return {oe, ou, hi, lo, 1'b1};
  endfunction

  function automatic logic [3:0] in_exp();
    logic [3:0] v;
    logic [1:0] ds;
    for (int k = 0; k < 4; k++) begin
      ds = pfm_pkg::IN_DESEL[k];
      if (md[pfm_pkg::IN_A_PAD[k]] == pfm_pkg::IN_A_MODE[k]) begin
        v[k] = pad_lvl[pfm_pkg::IN_A_PAD[k]];
      end else if (md[pfm_pkg::IN_B_PAD[k]] == pfm_pkg::IN_B_MODE[k]) begin
        v[k] = pad_lvl[pfm_pkg::IN_B_PAD[k]];
      end else begin
        v[k] = ds == pfm_pkg::DESEL_PIN ? pad_lvl[pfm_pkg::IN_HOME_PAD[k]] :
          ds == pfm_pkg::DESEL_ONE;
      end
    end
    return v;
  endfunction

  function automatic bit clash();
    bit c = 0;
    for (int k = 0; k < 4; k++) begin
      c |= md[pfm_pkg::IN_A_PAD[k]] == pfm_pkg::IN_A_MODE[k] &&
        md[pfm_pkg::IN_B_PAD[k]] == pfm_pkg::IN_B_MODE[k];
    end
    return c;
  endfunction

  task automatic note(input int k, input logic [23:0] e,
                      input logic [23:0] m, input int d);
    pfm_note_t t;
    t = '{k, e, m, cyc + d};
    nq.push_back(t);
  endtask

  task automatic cfg_note(input int d);
    note(1, {md[3], md[2], md[1], md[0], pen, pup}, 24'hFFFFFF, d);
  endtask

  task automatic pad_note(input bit por, input int d);
    logic [16:0] e;
    e = pad_exp(por);
    note(0, {7'h00, e}, msk, d);
  endtask

  // ========================================================
  // result watcher
  task automatic chk(input logic [23:0] o);
    tests_run++;
    if ((o & n.msk) !== (n.exp & n.msk)) begin
      fails++;
      $display("FAIL t=%0t exp=%h got=%h", $time, n.exp & n.msk, o & n.msk);
    end
  endtask
  task automatic cmp_pad();
    chk({7'h00, oe_o, out_o, pull_hi_o, pull_lo_o, out_o[1] ^ prev1});
  endtask
  task automatic cmp_cfg();
    chk({mode_o, pen_o, pup_o});
  endtask
  task automatic cmp_in();
    chk({20'h00000, in_o});
  endtask

  always @(negedge mclk) begin
    while (nq.size() > 0 && nq[0].at <= cyc) begin
      n = nq.pop_front();
      case (n.kind)
        0: cmp_pad();
        1: cmp_cfg();
        default: cmp_in();
      endcase
    end
    prev1 <= out_o[1];
  end

  // ========================================================
  // stimulus
  task automatic wr(input logic [1:0] p, input logic [3:0] m,
                    input logic e, input logic u);
    we = 1'b1;
    wpad = p;
    wmode = m;
    wpe = e;
    wpu = u;
    @(negedge mclk);
    we = 1'b0;
  endtask

  task automatic warm_rel();
    warm = 1'b0;
    ovr = 4'hF;
    md = pfm_pkg::REL_MODE;
    pen = pfm_pkg::PULL_EN_RST;
    pup = pfm_pkg::PULL_UP_RST;
    cfg_note(3);
    pad_note(0, 3);
    pad_note(0, 4);
    repeat (6) @(negedge mclk);
    $display("test warm release done");
  endtask

  task automatic rand_run(input int cnt);
    logic [1:0] p;
    for (int i = 0; i < cnt; i++) begin
      p = i < 4 ? 2'(i) : 2'(rnd());
      md[p] = 4'(rnd());
      while (!pfm_pkg::DEF_MODES[p][md[p]]) md[p] = 4'(rnd());
      if (clash()) md[p] = pfm_pkg::MODE_HIZ;
      pen[p] = 1'(rnd());
      pup[p] = 1'(rnd());
      ovr[p] = 1'b0;
      fo = {rnd(), rnd()};
      fe = {rnd(), rnd()};
      ext = 4'(rnd());
      wr(p, md[p], pen[p], pup[p]);
      cfg_note(3);
      pad_note(0, 3);
      if (ovr == 4'h0) note(2, {20'h00000, in_exp()}, 24'hFFFFFF, 7);
      repeat (8) @(negedge mclk);
    end
    $display("test random done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    md = pfm_pkg::REL_MODE;
    pen = pfm_pkg::PULL_EN_RST;
    pup = pfm_pkg::PULL_UP_RST;
    ovr = 4'h0;
    repeat (3) @(negedge mclk);
    pad_note(1, 1);
    cfg_note(1);
    note(2, 24'h000000, 24'hFFFFFF, 1);
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    wr(2'h0, pfm_pkg::MODE_HIZ, 1'b0, 1'b0);
    pad_note(1, 2);
    cfg_note(2);
    repeat (3) @(negedge mclk);
    $display("test reset done");
    warm_rel();
    rand_run(30);
    warm = 1'b1;
    wr(2'h1, pfm_pkg::MODE_HIZ, 1'b1, 1'b1);
    pad_note(1, 3);
    cfg_note(3);
    repeat (4) @(negedge mclk);
    $display("test warm reentry done");
    warm_rel();
    rand_run(8);
    finish_test();
  end
endmodule
